// *** hw/dtc_pkg.sv ***
// constants and types shared by the dual timer/counter block
package dtc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h88;
	localparam logic [7:0] IDX_MODE = 8'h89;
	localparam logic [7:0] IDX_T0L  = 8'h8a;
	localparam logic [7:0] IDX_T1L  = 8'h8b;
	localparam logic [7:0] IDX_T0H  = 8'h8c;
	localparam logic [7:0] IDX_T1H  = 8'h8d;
	localparam logic [7:0] IDX_PIN  = 8'ha6;
	localparam logic [7:0] IDX_IEN  = 8'ha8;

	localparam int ADDR_W = 12;

	// timer_control fields
	localparam int CTRL_TF1 = 7;
	localparam int CTRL_TR1 = 6;
	localparam int CTRL_TF0 = 5;
	localparam int CTRL_TR0 = 4;
	localparam int CTRL_IE1 = 3;
	localparam int CTRL_IT1 = 2;
	localparam int CTRL_IE0 = 1;
	localparam int CTRL_IT0 = 0;

	// timer_mode fields
	localparam int MODE_TIMER_ONE_PIN_GATING = 7;
	localparam int MODE_CT1   = 6;
	localparam int MODE_M1_HI = 5;
	localparam int MODE_M1_LO = 4;
	localparam int MODE_TIMER_ZERO_PIN_GATING = 3;
	localparam int MODE_CT0   = 2;
	localparam int MODE_M0_HI = 1;
	localparam int MODE_M0_LO = 0;

	// interrupt_enable fields
	localparam int IEN_EA  = 7;
	localparam int IEN_ET1 = 3;
	localparam int IEN_EX1 = 2;
	localparam int IEN_ET0 = 1;
	localparam int IEN_EX0 = 0;

	// output control field
	localparam int PIN_OVF_OE = 0;

	// interrupt source numbering for request and acknowledge vectors
	localparam int SRC_IRQ_PIN_ZERO = 0;
	localparam int SRC_T0   = 1;
	localparam int SRC_IRQ_PIN_ONE = 2;
	localparam int SRC_T1   = 3;

	// synchronised pin numbering
	localparam int PIN_IRQ_PIN_ZERO = 0;
	localparam int PIN_IRQ_PIN_ONE = 1;
	localparam int PIN_CNT0 = 2;
	localparam int PIN_CNT1 = 3;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int         DIV64_W  = 6;

	typedef enum logic [1:0] {
		MODE_13     = 2'b00,
		MODE_16     = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT  = 2'b11
	} dtc_mode_t;

	function automatic logic dtc_mapped(input logic [7:0] idx);
		return (idx >= IDX_CTRL && idx <= IDX_T1H) || idx == IDX_PIN || idx == IDX_IEN;
	endfunction

endpackage

// *** hw/dtc_if.sv ***
// register access channel between the bus slave and the timer core
`timescale 1ns/10ps
`default_nettype none

interface dtc_if;
	logic       wr_en;
	logic [7:0] idx;
	logic [7:0] wr_data;
	logic [7:0] rd_data;

	modport slave (output wr_en, output idx, output wr_data, input rd_data);
	modport core  (input wr_en, input idx, input wr_data, output rd_data);
endinterface

`default_nettype wire

// *** hw/dtc_sync.sv ***
// two-stage pin synchroniser with falling edge pulse per bit
`timescale 1ns/10ps
`default_nettype none

module dtc_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] last_ff;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// idle pins are high, so reset high to avoid a false edge at release
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_ff[g] <= 1'b1;
					sync_ff[g] <= 1'b1;
					last_ff[g] <= 1'b1;
				end else begin
					meta_ff[g] <= raw_in[g];
					sync_ff[g] <= meta_ff[g];
					last_ff[g] <= sync_ff[g];
				end
			end
			assign level[g] = sync_ff[g];
			assign fall[g]  = last_ff[g] & ~sync_ff[g];
		end
	endgenerate
endmodule

`default_nettype wire

// *** hw/dtc_apb.sv ***
// apb slave front end with one registered answer per transfer
`timescale 1ns/10ps
`default_nettype none

module dtc_apb (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [dtc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	dtc_if.slave                           bus
);
	import dtc_pkg::*;

	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic        setup;
	logic        hit;

	assign setup = psel && !penable;
	assign hit   = paddr[ADDR_W-1:10] == '0 && paddr[1:0] == 2'b00 && dtc_mapped(paddr[9:2]);

	assign bus.idx     = paddr[9:2];
	assign bus.wr_data = pwdata[7:0];
	// narrow registers live in lane 0 only
	assign bus.wr_en   = psel && penable && pready_ff && pwrite && !pslverr_ff && pstrb[0];

	// answer is prepared in the setup cycle so prdata, pready and pslverr come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !hit;
			if (setup) begin
				prdata_ff <= (hit && !pwrite) ? {24'h0, bus.rd_data} : 32'h0;
			end
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
endmodule

`default_nettype wire

// *** hw/dtc_top.sv ***
// dual 8-bit-style timer/counter with external interrupt pin logic
// Operation
// - timer one counts only while its run bit is set, else holds
// - timer zero overflow flag set on overflow, cleared when cpu vectors
// - timer zero counts only while its run bit is set, else holds
// - pin one flag set on falling edge, cleared when cpu vectors
// - pin one trigger select: 0 low level, 1 falling edge
// - pin zero flag set on falling edge, cleared when cpu vectors
// - pin zero trigger select: 0 low level, 1 falling edge
// - timer one gating: with gate set, run only while pin one high
// - timer one source: every 2 clocks, or count pin one falling edge
// - timer one modes: 13-bit, 16-bit, 8-bit reload, stopped
// - timer zero gating: with gate set, run only while pin zero high
// - timer zero source: every 2 clocks, or count pin zero falling edge
// - timer zero modes: 13-bit, 16-bit, 8-bit reload from high byte
// - timer zero split mode: high byte runs on timer one run, sets its flag
// - all four count bytes read/write by software, reset to zero
// - output toggles at timer zero overflow rate over 32 when enabled
// - global enable low blocks all interrupt requests but not wake, high defers to own enables
// - timer one enable lets its overflow request an interrupt
// - pin one enable lets pin one request and wake from stop
// - timer one overflow flag set on overflow, cleared when cpu vectors
// - timer zero enable lets its overflow request an interrupt
// - pin zero enable lets pin zero request and wake from stop
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module dtc_top (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [dtc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       irq_pin_zero,
	input  wire logic                       irq_pin_one,
	input  wire logic                       count_pin_zero,
	input  wire logic                       count_pin_one,
	input  wire logic [3:0]                 irq_ack,
	output logic      [3:0]                 irq_req,
	output logic      [1:0]                 wake_req,
	output logic                            overflow_div_output,
	output logic                            overflow_div_output_oe
);
	import dtc_pkg::*;

	dtc_if bus_if ();

	logic [3:0] pin_lvl;
	logic [3:0] pin_fall;

	// configuration
	logic [7:0] mode_ff;
	logic [7:0] ien_ff;
	logic       pin_oe_ff;
	logic       tr0_ff;
	logic       tr1_ff;
	logic       it0_ff;
	logic       it1_ff;

	// flags
	logic       tf0_ff;
	logic       tf1_ff;
	logic       ie0_ff;
	logic       ie1_ff;

	// count bytes
	logic [7:0] t0l_ff;
	logic [7:0] t0h_ff;
	logic [7:0] t1l_ff;
	logic [7:0] t1h_ff;
	logic [7:0] nxt_t0l;
	logic [7:0] nxt_t0h;
	logic [7:0] nxt_t1l;
	logic [7:0] nxt_t1h;

	logic               half_ff;
	logic [DIV64_W-1:0] div64_ff;
	logic [3:0]         irq_req_ff;
	logic [1:0]         wake_ff;

	logic      wr_ctrl;
	logic      wr_mode;
	logic      wr_ien;
	logic      wr_pin;
	logic      sys_tick;
	dtc_mode_t t0_mode;
	dtc_mode_t t1_mode;
	logic      t0_inc;
	logic      t1_inc;
	logic      th0_inc;
	logic      t0_ovf;
	logic      t1_ovf;
	logic      th0_ovf;
	logic      set_tf1;
	logic      ie0_view;
	logic      ie1_view;
	logic [16:0] t0_step;
	logic [16:0] t1_step;

	dtc_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (bus_if.slave)
	);

	dtc_sync #(
		.WIDTH (4)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.raw_in  ({count_pin_one, count_pin_zero, irq_pin_one, irq_pin_zero}),
		.level   (pin_lvl),
		.fall    (pin_fall)
	);

	assign wr_ctrl = bus_if.wr_en && bus_if.idx == IDX_CTRL;
	assign wr_mode = bus_if.wr_en && bus_if.idx == IDX_MODE;
	assign wr_ien  = bus_if.wr_en && bus_if.idx == IDX_IEN;
	assign wr_pin  = bus_if.wr_en && bus_if.idx == IDX_PIN;

	// one increment step: {overflow, high, low}; split means low byte alone
	function automatic logic [16:0] dtc_step(input dtc_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			MODE_13: begin
				r[4:0] = lo[4:0] + 5'h01;
				if (lo[4:0] == 5'h1f) begin
					r[15:8] = hi + 8'h01;
					r[16]   = hi == 8'hff;
				end
			end
			MODE_16: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			MODE_RELOAD: begin
				r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
				r[16]  = lo == 8'hff;
			end
			MODE_SPLIT: begin
				r[7:0] = lo + 8'h01;
				r[16]  = lo == 8'hff;
			end
			default: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction

	// system rate source: one pulse every second clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_ff <= 1'b0;
		end else begin
			half_ff <= !half_ff;
		end
	end
	assign sys_tick = half_ff;

	assign t0_mode = dtc_mode_t'(mode_ff[MODE_M0_HI:MODE_M0_LO]);
	assign t1_mode = dtc_mode_t'(mode_ff[MODE_M1_HI:MODE_M1_LO]);

	assign t0_inc = tr0_ff
		&& (!mode_ff[MODE_TIMER_ZERO_PIN_GATING] || pin_lvl[PIN_IRQ_PIN_ZERO])
		&& (mode_ff[MODE_CT0] ? pin_fall[PIN_CNT0] : sys_tick);

	// mode 11 halts timer one
	assign t1_inc = tr1_ff
		&& t1_mode != MODE_SPLIT
		&& (!mode_ff[MODE_TIMER_ONE_PIN_GATING] || pin_lvl[PIN_IRQ_PIN_ONE])
		&& (mode_ff[MODE_CT1] ? pin_fall[PIN_CNT1] : sys_tick);

	// split high byte borrows timer one's run bit, always at system rate
	assign th0_inc = t0_mode == MODE_SPLIT && tr1_ff && sys_tick;

	assign t0_step = dtc_step(t0_mode, t0l_ff, t0h_ff);
	assign t1_step = dtc_step(t1_mode, t1l_ff, t1h_ff);

	assign t0_ovf  = t0_inc && t0_step[16];
	assign t1_ovf  = t1_inc && t1_step[16];
	assign th0_ovf = th0_inc && t0h_ff == 8'hff;
	// while timer zero is split, timer one runs on but its flag belongs to the high byte
	assign set_tf1 = (t0_mode == MODE_SPLIT) ? th0_ovf : t1_ovf;

	// software write to a byte wins over a count in the same cycle
	always_comb begin
		nxt_t0l = t0_inc ? t0_step[7:0] : t0l_ff;
		nxt_t0h = t0h_ff;
		if (t0_mode == MODE_SPLIT) begin
			if (th0_inc) begin
				nxt_t0h = t0h_ff + 8'h01;
			end
		end else if (t0_inc) begin
			nxt_t0h = t0_step[15:8];
		end
		nxt_t1l = t1_inc ? t1_step[7:0] : t1l_ff;
		nxt_t1h = t1_inc ? t1_step[15:8] : t1h_ff;
		if (bus_if.wr_en) begin
			case (bus_if.idx)
				IDX_T0L: nxt_t0l = bus_if.wr_data;
				IDX_T0H: nxt_t0h = bus_if.wr_data;
				IDX_T1L: nxt_t1l = bus_if.wr_data;
				IDX_T1H: nxt_t1h = bus_if.wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0l_ff <= RST_BYTE;
			t0h_ff <= RST_BYTE;
			t1l_ff <= RST_BYTE;
			t1h_ff <= RST_BYTE;
		end else begin
			t0l_ff <= nxt_t0l;
			t0h_ff <= nxt_t0h;
			t1l_ff <= nxt_t1l;
			t1h_ff <= nxt_t1h;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff   <= RST_BYTE;
			ien_ff    <= RST_BYTE;
			pin_oe_ff <= 1'b0;
			tr0_ff    <= 1'b0;
			tr1_ff    <= 1'b0;
			it0_ff    <= 1'b0;
			it1_ff    <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_ff <= bus_if.wr_data;
			end
			if (wr_ien) begin
				ien_ff <= bus_if.wr_data;
			end
			if (wr_pin) begin
				pin_oe_ff <= bus_if.wr_data[PIN_OVF_OE];
			end
			if (wr_ctrl) begin
				tr0_ff <= bus_if.wr_data[CTRL_TR0];
				tr1_ff <= bus_if.wr_data[CTRL_TR1];
				it0_ff <= bus_if.wr_data[CTRL_IT0];
				it1_ff <= bus_if.wr_data[CTRL_IT1];
			end
		end
	end

	// overflow flags: hardware set beats vector or software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf0_ff <= 1'b0;
			tf1_ff <= 1'b0;
		end else begin
			if (t0_ovf) begin
				tf0_ff <= 1'b1;
			end else if (wr_ctrl) begin
				tf0_ff <= bus_if.wr_data[CTRL_TF0];
			end else if (irq_ack[SRC_T0]) begin
				tf0_ff <= 1'b0;
			end
			if (set_tf1) begin
				tf1_ff <= 1'b1;
			end else if (wr_ctrl) begin
				tf1_ff <= bus_if.wr_data[CTRL_TF1];
			end else if (irq_ack[SRC_T1]) begin
				tf1_ff <= 1'b0;
			end
		end
	end

	// pin flags latch only in edge mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie0_ff <= 1'b0;
			ie1_ff <= 1'b0;
		end else begin
			if (it0_ff && pin_fall[PIN_IRQ_PIN_ZERO]) begin
				ie0_ff <= 1'b1;
			end else if (wr_ctrl) begin
				ie0_ff <= bus_if.wr_data[CTRL_IE0];
			end else if (irq_ack[SRC_IRQ_PIN_ZERO]) begin
				ie0_ff <= 1'b0;
			end
			if (it1_ff && pin_fall[PIN_IRQ_PIN_ONE]) begin
				ie1_ff <= 1'b1;
			end else if (wr_ctrl) begin
				ie1_ff <= bus_if.wr_data[CTRL_IE1];
			end else if (irq_ack[SRC_IRQ_PIN_ONE]) begin
				ie1_ff <= 1'b0;
			end
		end
	end

	// level mode: request follows the low pin, so an ack cannot lose it
	assign ie0_view = it0_ff ? ie0_ff : !pin_lvl[PIN_IRQ_PIN_ZERO];
	assign ie1_view = it1_ff ? ie1_ff : !pin_lvl[PIN_IRQ_PIN_ONE];

	// requests and stop-mode wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req_ff <= 4'h0;
			wake_ff    <= 2'h0;
		end else begin
			irq_req_ff[SRC_IRQ_PIN_ZERO] <= ien_ff[IEN_EA] && ien_ff[IEN_EX0] && ie0_view;
			irq_req_ff[SRC_T0]   <= ien_ff[IEN_EA] && ien_ff[IEN_ET0] && tf0_ff;
			irq_req_ff[SRC_IRQ_PIN_ONE] <= ien_ff[IEN_EA] && ien_ff[IEN_EX1] && ie1_view;
			irq_req_ff[SRC_T1]   <= ien_ff[IEN_EA] && ien_ff[IEN_ET1] && tf1_ff;
			// wake ignores the global enable so a masked core still wakes
			wake_ff[0] <= ien_ff[IEN_EX0] && ie0_view;
			wake_ff[1] <= ien_ff[IEN_EX1] && ie1_view;
		end
	end

	// divide-by-64 of timer zero overflows; msb gives half period of 32
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div64_ff <= '0;
		end else if (t0_ovf) begin
			div64_ff <= div64_ff + DIV64_W'(1);
		end
	end

	assign overflow_div_output    = div64_ff[DIV64_W-1];
	assign overflow_div_output_oe = pin_oe_ff;
	assign irq_req                = irq_req_ff;
	assign wake_req               = wake_ff;

	// read view of the register file
	always_comb begin
		case (bus_if.idx)
			IDX_CTRL: bus_if.rd_data = {tf1_ff, tr1_ff, tf0_ff, tr0_ff, ie1_view, it1_ff, ie0_view, it0_ff};
			IDX_MODE: bus_if.rd_data = mode_ff;
			IDX_T0L:  bus_if.rd_data = t0l_ff;
			IDX_T1L:  bus_if.rd_data = t1l_ff;
			IDX_T0H:  bus_if.rd_data = t0h_ff;
			IDX_T1H:  bus_if.rd_data = t1h_ff;
			IDX_PIN:  bus_if.rd_data = {7'h00, pin_oe_ff};
			IDX_IEN:  bus_if.rd_data = ien_ff;
			default:  bus_if.rd_data = 8'h00;
		endcase
	end
endmodule

`default_nettype wire

// *** tb/dtc_asserts.sv ***
// port-level checks for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module dtc_asserts (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [dtc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [3:0]                 pstrb,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic [3:0]                 irq_ack,
	input wire logic [3:0]                 irq_req,
	input wire logic [1:0]                 wake_req,
	input wire logic                       overflow_div_output_oe
);
	import dtc_pkg::*;
	logic [7:0] ien_ff;
	logic       oe_ff;
	logic [7:0] idx;
	logic       wr;
	logic       bad;
	logic [3:0] mask;
	logic [1:0] wmask;
	assign idx = paddr[9:2];
	assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
	assign bad = paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0 || !(idx inside {[IDX_CTRL:IDX_T1H], IDX_PIN, IDX_IEN});
	// shadow copies of the enables, taken from completed bus writes
	assign mask = ien_ff[3:0] & {4{ien_ff[IEN_EA]}};
	assign wmask = {ien_ff[IEN_EX1], ien_ff[IEN_EX0]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ien_ff <= 8'h00;
		else if (wr && idx == IDX_IEN)
			ien_ff <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oe_ff <= 1'b0;
		else if (wr && idx == IDX_PIN)
			oe_ff <= pwdata[PIN_OVF_OE];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer");
	chk_err_map: assert property (psel && !penable |=> pslverr == bad) else $error("bad error flag");
	chk_read_pad: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
		else $error("read data padding");
	chk_req_gate: assert property ((irq_req & ~$past(mask)) == 4'h0) else $error("ungated request");
	chk_wake_gate: assert property ((wake_req & ~$past(wmask)) == 2'h0) else $error("ungated wake");
	chk_ack_clear: assert property (irq_ack[SRC_T0] |-> ##2 !irq_req[SRC_T0]) else $error("ack ignored");
	chk_oe_follow: assert property (wr && idx == IDX_PIN |=> ##[0:1] overflow_div_output_oe == oe_ff)
		else $error("output enable wrong");
endmodule
bind dtc_top dtc_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
	.pready, .pslverr, .irq_ack, .irq_req, .wake_req, .overflow_div_output_oe);
`default_nettype wire

// *** tb/dtc_pins.sv ***
// pin and acknowledge model for the far side of the timer block
`timescale 1ns/10ps
`default_nettype none
module dtc_pins (
	input  wire logic       pclk,
	output logic            irq_pin_zero,
	output logic            irq_pin_one,
	output logic            count_pin_zero,
	output logic            count_pin_one,
	output logic      [3:0] irq_ack
);
	initial begin
		irq_pin_zero = 1'b1;
		irq_pin_one = 1'b1;
		count_pin_zero = 1'b1;
		count_pin_one = 1'b1;
		irq_ack = 4'h0;
	end
	// each level held three clocks so the synchroniser cannot miss it
	task automatic set_pin(input bit cnt, input bit one, input bit lvl);
		@(posedge pclk);
		case ({cnt, one})
			2'b00: irq_pin_zero <= lvl;
			2'b01: irq_pin_one <= lvl;
			2'b10: count_pin_zero <= lvl;
			default: count_pin_one <= lvl;
		endcase
		repeat (2) @(posedge pclk);
	endtask
	task automatic ack(input int src);
		@(posedge pclk);
		irq_ack <= 4'(1 << src);
		@(posedge pclk);
		irq_ack <= 4'h0;
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import dtc_pkg::*;
	localparam logic [7:0] IDXS [8] = '{IDX_CTRL, IDX_MODE, IDX_T0L, IDX_T1L, IDX_T0H, IDX_T1H, IDX_PIN, IDX_IEN};
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, overflow_div_output, err;
	logic              irq_pin_zero, irq_pin_one, count_pin_zero, count_pin_one, overflow_div_output_oe;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb, irq_ack, irq_req;
	logic [1:0]        wake_req;
	logic [7:0]        v, rb, lo, fl;
	int                error_cnt, total_checks, cyc, n, src;
	dtc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.irq_pin_zero, .irq_pin_one, .count_pin_zero, .count_pin_one, .irq_ack, .irq_req, .wake_req,
		.overflow_div_output, .overflow_div_output_oe);
	dtc_pins pins_u (.pclk, .irq_pin_zero, .irq_pin_one, .count_pin_zero, .count_pin_one, .irq_ack);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// look at the answer mid-cycle, where it has settled, then complete on the next rising edge
		do begin
			@(negedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
			error_cnt++;
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'h0, i, 2'h0}, d);
	endtask
	// a value inside the window reads back as its lower bound
	task automatic rdr(input string nm, input logic [7:0] i, input logic [7:0] l, input logic [7:0] h);
		apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
		check(nm, (rd[7:0] >= l && rd[7:0] <= h && rd[31:8] == 24'h0) === 1'b1 ? {24'h0, l} : rd, {24'h0, l});
	endtask
	task automatic run(input logic [7:0] c, input int k);
		wr(IDX_CTRL, c);
		repeat (k) @(posedge pclk);
		wr(IDX_CTRL, 8'h00);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rdr("reset value", IDXS[i], 8'h00, 8'h00);
		for (int i = 2; i < 6; i++) wr(IDXS[i], 8'h5a ^ 8'(i));
		for (int i = 2; i < 6; i++) rdr("count byte", IDXS[i], 8'h5a ^ 8'(i), 8'h5a ^ 8'(i));
		apb(1'b1, 12'h2a4, 8'hff);
		check("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h221, 8'h00);
		check("misaligned error", {31'h0, err}, 32'h1);
		for (int t = 0; t < 2; t++) begin
			rb = t ? 8'h40 : 8'h10;
			lo = t ? IDX_T1L : IDX_T0L;
			fl = t ? 8'h80 : 8'h20;
			src = t ? SRC_T1 : SRC_T0;
			wr(IDX_MODE, 8'h11);
			wr(IDX_T0L, 8'h00);
			wr(IDX_T1L, 8'h00);
			run(rb, 40);
			rdr("timer rate", lo, 8'd20, 8'd23);
			v = rd[7:0];
			rdr("held value", lo, v, v);
			rdr("other timer idle", t ? IDX_T0L : IDX_T1L, 8'h00, 8'h00);
			wr(IDX_MODE, t ? 8'h91 : 8'h19);
			pins_u.set_pin(1'b0, t[0], 1'b0);
			wr(lo, 8'h00);
			run(rb, 40);
			rdr("gate pin low", lo, 8'h00, 8'h00);
			pins_u.set_pin(1'b0, t[0], 1'b1);
			run(rb, 40);
			rdr("gate pin high", lo, 8'd20, 8'd23);
			wr(IDX_MODE, t ? 8'h51 : 8'h15);
			wr(lo, 8'h00);
			wr(IDX_CTRL, rb);
			repeat (5) begin
				pins_u.set_pin(1'b1, t[0], 1'b0);
				pins_u.set_pin(1'b1, t[0], 1'b1);
			end
			rdr("count pin edges", lo, 8'd5, 8'd5);
			wr(IDX_MODE, 8'h11);
			wr(lo + 8'h2, 8'hff);
			wr(lo, 8'hf8);
			wr(IDX_IEN, 8'h0a);
			wr(IDX_CTRL, rb);
			repeat (30) @(posedge pclk);
			check("global off request", {31'h0, irq_req[src]}, 32'h0);
			rdr("overflow flag", IDX_CTRL, rb | fl, rb | fl);
			wr(IDX_CTRL, fl);
			rdr("wrap to zero", lo + 8'h2, 8'h00, 8'h00);
			wr(IDX_IEN, 8'h8a);
			repeat (2) @(posedge pclk);
			check("timer request", {31'h0, irq_req[src]}, 32'h1);
			pins_u.ack(src);
			repeat (3) @(posedge pclk);
			check("request after ack", {31'h0, irq_req[src]}, 32'h0);
			rdr("flag after ack", IDX_CTRL, 8'h00, 8'h00);
			wr(IDX_MODE, 8'h00);
			wr(lo + 8'h2, 8'h00);
			wr(lo, 8'h1e);
			run(rb, 10);
			rdr("prescaler carry", lo + 8'h2, 8'h01, 8'h01);
			wr(IDX_MODE, 8'h22);
			wr(lo + 8'h2, 8'hf0);
			wr(lo, 8'hfe);
			run(rb, 20);
			rdr("reloaded low", lo, 8'hf0, 8'hfd);
			rdr("reload source", lo + 8'h2, 8'hf0, 8'hf0);
		end
		wr(IDX_MODE, 8'h30);
		wr(IDX_T1L, 8'h00);
		run(8'h40, 20);
		rdr("stopped mode", IDX_T1L, 8'h00, 8'h00);
		wr(IDX_MODE, 8'h03);
		wr(IDX_T0L, 8'h00);
		wr(IDX_T0H, 8'hfc);
		wr(IDX_CTRL, 8'h40);
		repeat (20) @(posedge pclk);
		rdr("split high flag", IDX_CTRL, 8'hc0, 8'hc0);
		rdr("split low idle", IDX_T0L, 8'h00, 8'h00);
		wr(IDX_IEN, 8'h85);
		for (int p = 0; p < 2; p++) begin
			rb = p ? 8'h04 : 8'h01;
			fl = p ? 8'h08 : 8'h02;
			src = p ? SRC_IRQ_PIN_ONE : SRC_IRQ_PIN_ZERO;
			wr(IDX_CTRL, rb);
			pins_u.set_pin(1'b0, p[0], 1'b0);
			pins_u.set_pin(1'b0, p[0], 1'b1);
			rdr("edge flag", IDX_CTRL, rb | fl, rb | fl);
			check("pin request", {31'h0, irq_req[src]}, 32'h1);
			check("wake request", {31'h0, wake_req[p]}, 32'h1);
			pins_u.ack(src);
			repeat (3) @(posedge pclk);
			rdr("flag after ack", IDX_CTRL, rb, rb);
			wr(IDX_CTRL, 8'h00);
			pins_u.set_pin(1'b0, p[0], 1'b0);
			rdr("level low", IDX_CTRL, fl, fl);
			pins_u.set_pin(1'b0, p[0], 1'b1);
			rdr("level high", IDX_CTRL, 8'h00, 8'h00);
		end
		wr(IDX_PIN, 8'h01);
		wr(IDX_MODE, 8'h02);
		wr(IDX_T0H, 8'hff);
		wr(IDX_T0L, 8'hff);
		wr(IDX_CTRL, 8'h10);
		check("output enable", {31'h0, overflow_div_output_oe}, 32'h1);
		// one overflow per tick, so 32 overflows between output changes
		for (int e = 0; e < 2; e++) begin
			v[0] = overflow_div_output;
			n = 0;
			while (overflow_div_output === v[0] && n < 200) begin
				@(negedge pclk);
				n++;
			end
		end
		check("output toggle spacing", n, 64);
		wr(IDX_PIN, 8'h00);
		repeat (2) @(posedge pclk);
		check("output disabled", {31'h0, overflow_div_output_oe}, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
